// ---- design/spp_defines.svh ----
// Constants for the scan pixel pipeline: offsets, fields, resets, memory map
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// ----------------------------------------------------------------
// APB register byte addresses, and the word index of the config register
// ----------------------------------------------------------------
`define SPP_GSEL_ADDR 12'h000
`define SPP_GADDR_ADDR 12'h004
`define SPP_GDATA_ADDR 12'h008
`define SPP_STATUS_ADDR 12'h00c
`define SPP_CFG_INDEX 12'h009
`define SPP_CFG_ADDR 12'h024

// ----------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------
`define SPP_CFG_DIV_LSB 0
`define SPP_CFG_DIV_MSB 2
`define SPP_CFG_DEPTH_LSB 3
`define SPP_CFG_DEPTH_MSB 4
`define SPP_CFG_OUT14_BIT 5
`define SPP_CFG_RESET 6'h00

// ----------------------------------------------------------------
// External memory map, in 16-bit words
// ----------------------------------------------------------------
`define SPP_OFF_BASE 20'h00000
`define SPP_GAIN_BASE 20'h0c000
`define SPP_GAMMA_BASE 20'h18000
`define SPP_LBUF_BASE 20'h1b000
`define SPP_LBUF_LAST 20'h3ffff
`define SPP_COEF_STRIDE 20'h04000
`define SPP_GAMMA_STRIDE 20'h01000

// ----------------------------------------------------------------
// Arithmetic limits
// ----------------------------------------------------------------
`define SPP_GAIN_SHIFT 14
`define SPP_FULL_SCALE 14'h3fff

`endif

// ---- design/spp_pixel_pipeline.sv ----
// Scan pixel pipeline: averaging, offset, gain, gamma, packing, buffer
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"

module spp_pixel_pipeline (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel stream from the converter
  input wire logic pix_valid,
  input wire logic [13:0] pix_sample,
  input wire logic [1:0] pix_colour,
  input wire logic pix_first,
  output logic pix_ready,
  // External memory port
  output logic mem_req,
  output logic mem_we,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Line buffer fill pointer
  output logic [19:0] lbuf_wptr
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] cfg;
  logic [1:0] gsel;
  logic [11:0] gaddr;
  logic [15:0] gdata;
  logic cpu_pend;
  logic cpu_done;
  logic [15:0] cpu_rd;
  logic cpu_we_r;

  wire logic [2:0] horizontal_divider_setting;
  wire logic [1:0] depth;
  wire logic out14;
  assign horizontal_divider_setting =
    cfg[`SPP_CFG_DIV_MSB:`SPP_CFG_DIV_LSB];
  assign depth = cfg[`SPP_CFG_DEPTH_MSB:`SPP_CFG_DEPTH_LSB];
  assign out14 = cfg[`SPP_CFG_OUT14_BIT];

  wire logic hit_gsel;
  wire logic hit_gaddr;
  wire logic hit_gdata;
  wire logic hit_status;
  wire logic hit_cfg;
  wire logic hit_any;
  wire logic access;
  wire logic done_xfer;
  wire logic next_pready;
  assign hit_gsel = paddr == `SPP_GSEL_ADDR;
  assign hit_gaddr = paddr == `SPP_GADDR_ADDR;
  assign hit_gdata = paddr == `SPP_GDATA_ADDR;
  assign hit_status = paddr == `SPP_STATUS_ADDR;
  assign hit_cfg = paddr == `SPP_CFG_ADDR;
  assign hit_any = hit_gsel | hit_gaddr | hit_gdata | hit_status | hit_cfg;
  assign access = psel & penable;
  assign done_xfer = access & pready;
  // Gamma port accesses wait for the memory round trip
  assign next_pready = access & ~pready & (~hit_gdata | cpu_done);

  wire logic [31:0] rd_mux;
  assign rd_mux = hit_gsel ? {30'h0, gsel} :
                  hit_gaddr ? {20'h0, gaddr} :
                  hit_gdata ? {16'h0, cpu_rd} :
                  hit_status ? {12'h0, lbuf_wptr} :
                  hit_cfg ? {26'h0, cfg} : 32'h0;

  wire logic cpu_start;
  assign cpu_start = access & hit_gdata & ~cpu_done & ~cpu_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready & ~hit_any;
      prdata <= (next_pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `SPP_CFG_RESET;
      gsel <= 2'h0;
      gaddr <= 12'h0;
    end else if (done_xfer & pwrite) begin
      if (hit_cfg) cfg <= pwdata[5:0];
      if (hit_gsel) gsel <= pwdata[1:0];
      if (hit_gaddr) gaddr <= pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Horizontal reduction
  // ----------------------------------------------------------------
  logic [17:0] acc;
  logic [3:0] phase;
  logic [13:0] in_idx;
  logic avg_valid;
  logic [13:0] avg_pix;
  logic [1:0] avg_colour;
  logic [13:0] avg_idx;
  logic avg_first;
  logic line_new;

  wire logic [15:0] adc_word;
  assign adc_word = {pix_sample, 2'b00};

  wire logic take;
  assign take = pix_valid & pix_ready;

  wire logic [3:0] group_len;
  wire logic is_1p5;
  assign is_1p5 = horizontal_divider_setting == spp_pkg::SPP_DIV_1P5;
  assign group_len =
    (horizontal_divider_setting == spp_pkg::SPP_DIV_1) ? 4'd1 :
    is_1p5 ? 4'd3 :
    (horizontal_divider_setting == spp_pkg::SPP_DIV_2) ? 4'd2 :
    (horizontal_divider_setting == spp_pkg::SPP_DIV_3) ? 4'd3 :
    (horizontal_divider_setting == spp_pkg::SPP_DIV_4) ? 4'd4 :
    (horizontal_divider_setting == spp_pkg::SPP_DIV_6) ? 4'd6 :
    (horizontal_divider_setting == spp_pkg::SPP_DIV_8) ? 4'd8 : 4'd12;

  wire logic [3:0] cur_phase;
  wire logic [17:0] base_acc;
  wire logic [17:0] samp;
  assign cur_phase = pix_first ? 4'd0 : phase;
  assign base_acc = (pix_first | (cur_phase == 4'd0)) ? 18'h0 : acc;
  assign samp = {4'h0, adc_word[15:2]};

  // 1.5 mixes weights 2:1 then 1:2 over three inputs
  wire logic [17:0] sum;
  wire logic emit;
  wire logic [17:0] carry_acc;
  assign sum = (is_1p5 & (cur_phase == 4'd2)) ? base_acc + (samp << 1) :
               base_acc + samp;
  assign emit = is_1p5 ? (cur_phase != 4'd0) :
                (cur_phase == group_len - 4'd1);
  assign carry_acc = is_1p5 ? ((cur_phase == 4'd0) ? samp << 1 :
                     (cur_phase == 4'd1) ? samp : 18'h0) : sum;

  logic [17:0] quot;
  always_comb begin
    case (horizontal_divider_setting)
      spp_pkg::SPP_DIV_1: quot = sum;
      spp_pkg::SPP_DIV_1P5: quot = sum / 18'd3;
      spp_pkg::SPP_DIV_2: quot = sum >> 1;
      spp_pkg::SPP_DIV_3: quot = sum / 18'd3;
      spp_pkg::SPP_DIV_4: quot = sum >> 2;
      spp_pkg::SPP_DIV_6: quot = sum / 18'd6;
      spp_pkg::SPP_DIV_8: quot = sum >> 3;
      default: quot = sum / 18'd12;
    endcase
  end

  wire logic next_phase_wrap;
  wire logic [3:0] next_phase;
  assign next_phase_wrap = cur_phase == group_len - 4'd1;
  assign next_phase = next_phase_wrap ? 4'd0 : cur_phase + 4'd1;

  wire logic work_take;
  wire logic next_avg_valid;
  assign next_avg_valid = (avg_valid & ~work_take) | (take & emit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 18'h0;
      phase <= 4'd0;
      in_idx <= 14'h0;
      line_new <= 1'b1;
    end else if (take) begin
      acc <= carry_acc;
      phase <= next_phase;
      if (emit) begin
        in_idx <= pix_first ? 14'h1 : in_idx + 14'h1;
        line_new <= 1'b0;
      end else if (pix_first) begin
        in_idx <= 14'h0;
        line_new <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_valid <= 1'b0;
      avg_pix <= 14'h0;
      avg_colour <= 2'h0;
      avg_idx <= 14'h0;
      avg_first <= 1'b0;
      pix_ready <= 1'b0;
    end else begin
      avg_valid <= next_avg_valid;
      pix_ready <= ~next_avg_valid;
      if (take & emit) begin
        avg_pix <= quot[13:0];
        avg_colour <= pix_colour;
        avg_idx <= pix_first ? 14'h0 : in_idx;
        avg_first <= pix_first | line_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // Correction, gamma and packing engine
  // ----------------------------------------------------------------
  spp_pkg::spp_state_t state;
  spp_pkg::spp_state_t next_state;
  logic [13:0] work;
  logic [1:0] work_colour;
  logic [13:0] work_idx;
  logic work_first;
  logic [15:0] pack;
  logic [4:0] pack_cnt;

  assign work_take = (state == spp_pkg::SPP_S_IDLE) & ~cpu_pend & avg_valid;

  wire logic [13:0] off_val;
  wire logic [13:0] sub_res;
  assign off_val = mem_rdata[15:2];
  assign sub_res = (off_val > work) ? 14'h0 : work - off_val;

  wire logic [29:0] product;
  wire logic [15:0] prod_hi;
  wire logic [13:0] gain_res;
  assign product = work * mem_rdata;
  assign prod_hi = product[29:14];
  assign gain_res = (prod_hi > 16'h3fff) ? `SPP_FULL_SCALE :
                    prod_hi[13:0];

  wire logic [19:0] coef_off;
  wire logic [19:0] gamma_addr;
  assign coef_off = {6'h0, work_idx} +
                    (`SPP_COEF_STRIDE * {18'h0, work_colour});
  assign gamma_addr = `SPP_GAMMA_BASE + {8'h0, work[13:2]} +
                      (`SPP_GAMMA_STRIDE * {18'h0, work_colour});

  // Packing: depth code 0..3 means 8, 4, 2, 1 bits per pixel
  wire logic [7:0] gam;
  wire logic [4:0] per_word;
  wire logic [15:0] pack_base;
  wire logic [4:0] cnt_base;
  logic [15:0] pack_in;
  assign gam = mem_rdata[7:0];
  assign per_word = 5'd2 << depth;
  // A new line restarts the word, so a partial word is silently lost
  assign pack_base = work_first ? 16'h0 : pack;
  assign cnt_base = work_first ? 5'd0 : pack_cnt;
  always_comb begin
    case (depth)
      2'd0: pack_in = {pack_base[7:0], gam};
      2'd1: pack_in = {pack_base[11:0], gam[7:4]};
      2'd2: pack_in = {pack_base[13:0], gam[7:6]};
      default: pack_in = {pack_base[14:0], gam[7]};
    endcase
  end

  // 14-bit mode reuses the gamma region, so the buffer starts there
  wire logic [19:0] buf_base;
  wire logic [19:0] wptr_inc;
  assign buf_base = out14 ? `SPP_GAMMA_BASE : `SPP_LBUF_BASE;
  assign wptr_inc = (lbuf_wptr == `SPP_LBUF_LAST) ? buf_base :
                    lbuf_wptr + 20'h1;

  wire logic mem_done;
  assign mem_done = mem_req & mem_ack;

  always_comb begin
    next_state = state;
    case (state)
      spp_pkg::SPP_S_IDLE: begin
        if (cpu_pend) next_state = spp_pkg::SPP_S_CPU;
        else if (avg_valid) next_state = spp_pkg::SPP_S_OFF;
      end
      spp_pkg::SPP_S_OFF:
        if (mem_done) next_state = spp_pkg::SPP_S_GAIN;
      spp_pkg::SPP_S_GAIN: begin
        if (mem_done) next_state = out14 ? spp_pkg::SPP_S_WRITE :
                                   spp_pkg::SPP_S_GAMMA;
      end
      spp_pkg::SPP_S_GAMMA: begin
        if (mem_done) next_state = (cnt_base + 5'd1 == per_word) ?
          spp_pkg::SPP_S_WRITE : spp_pkg::SPP_S_IDLE;
      end
      spp_pkg::SPP_S_WRITE:
        if (mem_done) next_state = spp_pkg::SPP_S_IDLE;
      spp_pkg::SPP_S_CPU:
        if (mem_done) next_state = spp_pkg::SPP_S_IDLE;
      default: next_state = spp_pkg::SPP_S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spp_pkg::SPP_S_IDLE;
      work <= 14'h0;
      work_colour <= 2'h0;
      work_idx <= 14'h0;
      work_first <= 1'b0;
      pack <= 16'h0;
      pack_cnt <= 5'd0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 20'h0;
      mem_wdata <= 16'h0;
    end else begin
      state <= next_state;
      case (state)
        spp_pkg::SPP_S_IDLE: begin
          if (cpu_pend) begin
            mem_req <= 1'b1;
            mem_we <= cpu_we_r;
            mem_addr <= `SPP_GAMMA_BASE + {8'h0, gaddr} +
                        (`SPP_GAMMA_STRIDE * {18'h0, gsel});
            mem_wdata <= gdata;
          end else if (avg_valid) begin
            work <= avg_pix;
            work_colour <= avg_colour;
            work_idx <= avg_idx;
            work_first <= avg_first;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= `SPP_OFF_BASE + {6'h0, avg_idx} +
              (`SPP_COEF_STRIDE * {18'h0, avg_colour});
          end
        end
        spp_pkg::SPP_S_OFF: begin
          if (mem_done) begin
            work <= sub_res;
            mem_addr <= `SPP_GAIN_BASE + coef_off;
          end
        end
        spp_pkg::SPP_S_GAIN: begin
          if (mem_done) begin
            work <= gain_res;
            if (out14) begin
              mem_we <= 1'b1;
              mem_addr <= lbuf_wptr;
              mem_wdata <= {gain_res, 2'b00};
            end else begin
              mem_addr <= gamma_addr_n(gain_res, work_colour);
            end
          end
        end
        spp_pkg::SPP_S_GAMMA: begin
          if (mem_done) begin
            work_first <= 1'b0;
            if (cnt_base + 5'd1 == per_word) begin
              pack_cnt <= 5'd0;
              mem_we <= 1'b1;
              mem_addr <= lbuf_wptr;
              mem_wdata <= pack_in;
            end else begin
              pack <= pack_in;
              pack_cnt <= cnt_base + 5'd1;
              mem_req <= 1'b0;
            end
          end
        end
        default: begin
          if (mem_done) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
          end
        end
      endcase
    end
  end

  function automatic logic [19:0] gamma_addr_n(input logic [13:0] v,
                                               input logic [1:0] c);
    gamma_addr_n = `SPP_GAMMA_BASE + {8'h0, v[13:2]} +
                   (`SPP_GAMMA_STRIDE * {18'h0, c});
  endfunction

  // ----------------------------------------------------------------
  // Gamma port handshake and buffer pointer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_pend <= 1'b0;
      cpu_done <= 1'b0;
      cpu_rd <= 16'h0;
      cpu_we_r <= 1'b0;
      gdata <= 16'h0;
    end else begin
      if (cpu_start) begin
        cpu_pend <= 1'b1;
        cpu_we_r <= pwrite;
        if (pwrite) gdata <= pwdata[15:0];
      end else if ((state == spp_pkg::SPP_S_CPU) & mem_done) begin
        // Held until the answer, so a waiting access never runs twice
        cpu_pend <= 1'b0;
      end
      if ((state == spp_pkg::SPP_S_CPU) & mem_done) begin
        cpu_done <= 1'b1;
        if (~cpu_we_r) cpu_rd <= mem_rdata;
      end else if (done_xfer) begin
        cpu_done <= 1'b0;
      end
    end
  end

  wire logic buf_write;
  assign buf_write = mem_done & mem_we & (state == spp_pkg::SPP_S_WRITE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lbuf_wptr <= `SPP_LBUF_BASE;
    end else if (done_xfer & pwrite & hit_cfg) begin
      lbuf_wptr <= pwdata[`SPP_CFG_OUT14_BIT] ? `SPP_GAMMA_BASE :
                   `SPP_LBUF_BASE;
    end else if (buf_write) begin
      lbuf_wptr <= wptr_inc;
    end
  end

  // Unused write-data and gamma wires kept out of the datapath
  wire logic unused_ok;
  assign unused_ok = &{1'b0, gamma_addr[0], pwdata[31:16]};

endmodule
`default_nettype wire

// ---- design/spp_pkg.sv ----
// Types for the scan pixel pipeline
package spp_pkg;

  typedef enum logic [2:0] {
    SPP_S_IDLE = 3'b000,
    SPP_S_OFF = 3'b001,
    SPP_S_GAIN = 3'b010,
    SPP_S_GAMMA = 3'b011,
    SPP_S_WRITE = 3'b100,
    SPP_S_CPU = 3'b101
  } spp_state_t;

  typedef enum logic [2:0] {
    SPP_DIV_1 = 3'b000,
    SPP_DIV_1P5 = 3'b001,
    SPP_DIV_2 = 3'b010,
    SPP_DIV_3 = 3'b011,
    SPP_DIV_4 = 3'b100,
    SPP_DIV_6 = 3'b101,
    SPP_DIV_8 = 3'b110,
    SPP_DIV_12 = 3'b111
  } spp_div_t;

endpackage

// ---- tb/spp_mem_model.sv ----
// Behavioural external memory for the pixel pipeline
`timescale 1ns/10ps
`default_nettype none
// ----------
// Memory
// ----------
module spp_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  // Answers
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // Wait states per answer
  input wire logic [3:0] lat
);
  logic [15:0] mem [0:20'h3ffff];
  logic [3:0] cnt;
  // Data toggles outside the ack so a late sample is never plausible
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 16'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt >= lat) begin
          cnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
          end else begin
            mem_rdata <= mem[mem_addr];
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/spp_pipe_sva.sv ----
// Port-level assertions for the scan pixel pipeline
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"
// ----------
// Checker
// ----------
module spp_pipe_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [19:0] lbuf_wptr
);
  logic out14;
  logic gacc;
  logic [19:0] next_wptr;
  wire cfg_wr = psel && penable && pready && pwrite &&
    paddr == `SPP_CFG_ADDR;
  wire mapped = paddr inside {`SPP_GSEL_ADDR, `SPP_GADDR_ADDR,
    `SPP_GDATA_ADDR, `SPP_STATUS_ADDR, `SPP_CFG_ADDR};
  wire [19:0] base = out14 ? `SPP_GAMMA_BASE : `SPP_LBUF_BASE;
  assign next_wptr = (lbuf_wptr == `SPP_LBUF_LAST) ? base :
    lbuf_wptr + 20'h1;
  // Table traffic from the bus is not line data, so mask it out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out14 <= 1'b0;
      gacc <= 1'b0;
    end else begin
      if (cfg_wr) begin
        out14 <= pwdata[`SPP_CFG_OUT14_BIT];
      end
      gacc <= psel && paddr == `SPP_GDATA_ADDR && !pready;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_fast_answer: assert property (psel && $rose(penable) && mapped &&
    paddr != `SPP_GDATA_ADDR |=> pready)
    else $error("register answer not after one wait state");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_lbuf_addr: assert property (
    mem_req && mem_we && !gacc |-> mem_addr == lbuf_wptr)
    else $error("pixel write not at buffer pointer");
  a_wptr_step: assert property (
    mem_req && mem_we && mem_ack && !gacc && !cfg_wr |=>
      lbuf_wptr == $past(next_wptr))
    else $error("buffer pointer did not step");
  a_low_zero: assert property (
    mem_req && mem_we && out14 && !gacc |-> mem_wdata[1:0] == 2'b00)
    else $error("wide word low bits not zero");
  a_cfg_wptr: assert property (
    cfg_wr |=> lbuf_wptr == ($past(pwdata[5]) ? `SPP_GAMMA_BASE :
      `SPP_LBUF_BASE))
    else $error("buffer pointer not reset by config");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the scan pixel pipeline
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"
// ----------
// Bench
// ----------
module tb;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pix_valid, pix_first, pix_ready, mem_req, mem_we, mem_ack;
  logic [13:0] pix_sample;
  logic [1:0] pix_colour;
  logic [19:0] mem_addr, lbuf_wptr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [3:0] lat;
  int errors, compares;
  int dt[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  spp_pixel_pipeline dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_sample(pix_sample),
    .pix_colour(pix_colour), .pix_first(pix_first), .pix_ready(pix_ready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .lbuf_wptr(lbuf_wptr));
  spp_mem_model mm (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
  function automatic int smp(input int l, input int k);
    if (l == 0) return (k * 523 + 99) & 16383;
    if (l == 1) return (k * 311 + 1000) & 16383;
    return 12032 + k * 211;
  endfunction
  function automatic int offv(input int i);
    return (i == 1) ? 16383 : i * 13;
  endfunction
  function automatic int gainv(input int i);
    if (i == 2) return 0;
    if (i == 3) return 65535;
    return (i == 4) ? 16384 : 16384 + i * 300;
  endfunction
  function automatic int gam(input int c, input int e);
    return (e * 7 + c * 40) & 255;
  endfunction
  function automatic int epix(input int s, input int i);
    longint p;
    p = (s > offv(i)) ? s - offv(i) : 0;
    p = (p * gainv(i)) >> 14;
    return (p > 16383) ? 16383 : int'(p);
  endfunction
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    if (pready !== 1'b1) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfgw(input logic [5:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, `SPP_CFG_ADDR, {26'h0, v}, r, e);
  endtask
  task automatic line(input int l, input int cnt, input logic [1:0] c);
    int n;
    @(posedge pclk);
    for (int k = 0; k < cnt; k++) begin
      pix_valid <= 1'b1;
      pix_sample <= 14'(smp(l, k));
      pix_colour <= c;
      pix_first <= (k == 0);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pix_ready !== 1'b1 && n < 500);
      if (pix_ready !== 1'b1) errors++;
    end
    pix_valid <= 1'b0;
  endtask
  // Idle memory port for a while means the pipeline has drained
  task automatic settle();
    int q, n;
    q = 0;
    n = 0;
    while (q < 16 && n < 5000) begin
      @(posedge pclk);
      n++;
      q = (mem_req === 1'b0) ? q + 1 : 0;
    end
    if (q < 16) errors++;
  endtask
  task automatic preload();
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 32; i++) begin
        mm.mem[c * 16384 + i] = 16'(offv(i) * 4);
        mm.mem[`SPP_GAIN_BASE + c * 16384 + i] = 16'(gainv(i));
      end
      for (int e = 0; e < 4096; e++) begin
        mm.mem[`SPP_GAMMA_BASE + c * 4096 + e] = 16'(65280 | gam(c, e));
      end
    end
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, `SPP_CFG_ADDR, 32'h0, r, e);
    chk("cfg reset", 32'(`SPP_CFG_RESET), r);
    apb(1'b1, `SPP_CFG_ADDR, 32'h2b, r, e);
    apb(1'b0, `SPP_CFG_ADDR, 32'h0, r, e);
    chk("cfg", 32'h2b, r);
    chk("wptr base", 32'(`SPP_GAMMA_BASE), 32'(lbuf_wptr));
    apb(1'b1, 12'h010, 32'h1, r, e);
    chk("unmapped err", 32'h1, 32'(e));
  endtask
  task automatic t_reduce(input logic [2:0] dv);
    int h, n, a, g;
    h = dt[dv];
    cfgw({1'b1, 2'b00, dv});
    line(2, 13, 2'd0);
    settle();
    n = 26 / h;
    chk("out count", n, 32'(lbuf_wptr - `SPP_GAMMA_BASE));
    for (int k = 0; k < n; k++) begin
      g = 3 * (k / 2);
      if (dv == 3'd1) begin
        a = (k % 2 == 0) ? 2 * smp(2, g) + smp(2, g + 1) :
          smp(2, g + 1) + 2 * smp(2, g + 2);
        a = a / 3;
      end else begin
        a = 0;
        for (int j = 0; j < h / 2; j++) a += smp(2, k * h / 2 + j);
        a = a / (h / 2);
      end
      // Index 1 clamps, 2 zeroes, 3 saturates, 4 is unity
      chk("wide word", epix(a, k) * 4, mm.mem[`SPP_GAMMA_BASE + k]);
    end
  endtask
  task automatic t_pack(input logic [1:0] dp);
    int b, n, v;
    logic [15:0] w;
    b = 8 >> dp;
    n = 16 / b;
    cfgw({1'b0, dp, 3'b000});
    line(0, 2 * n - 1, 2'(dp % 3));
    line(1, n, 2'(dp % 3));
    settle();
    chk("pack count", 2, 32'(lbuf_wptr - `SPP_LBUF_BASE));
    for (int l = 0; l < 2; l++) begin
      w = 16'h0;
      for (int j = 0; j < n; j++) begin
        v = epix(smp(l, j), j);
        w = (w << b) | 16'(gam(dp % 3, v >> 2) >> (8 - b));
      end
      chk("packed", w, mm.mem[`SPP_LBUF_BASE + l]);
    end
  endtask
  task automatic t_gport();
    logic [31:0] r;
    logic e;
    apb(1'b1, `SPP_GSEL_ADDR, 32'h2, r, e);
    apb(1'b1, `SPP_GADDR_ADDR, 32'h123, r, e);
    apb(1'b1, `SPP_GDATA_ADDR, 32'h3c, r, e);
    chk("table write", 32'h3c, 32'(mm.mem[20'h1a123][7:0]));
    mm.mem[20'h1a124] = 16'hff5a;
    apb(1'b1, `SPP_GADDR_ADDR, 32'h124, r, e);
    apb(1'b0, `SPP_GDATA_ADDR, 32'h0, r, e);
    chk("table read", 32'h5a, 32'(r[7:0]));
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, pix_valid, pix_first, presetn} = 6'h00;
    {paddr, pwdata, pix_sample, pix_colour} = '0;
    lat = 4'h0;
    preload();
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    for (int v = 0; v < 8; v++) begin
      lat <= 4'(v % 4);
      t_reduce(3'(v));
    end
    preload();
    for (int d = 0; d < 4; d++) t_pack(2'(d));
    t_gport();
    end_sim();
  end
  initial begin
    repeat (50000) @(posedge pclk);
    errors++;
    end_sim();
  end
endmodule
bind spp_pixel_pipeline spp_pipe_sva sva_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .lbuf_wptr(lbuf_wptr));
`default_nettype wire
